// File: plldl_pkg.sv
/*
 * Constants shared by the PLL divider chain and lock detector: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a single 10 MHz system clock; slow clock pins are sampled, not used as clocks.
 */
`default_nettype none

package plldl_pkg;
    // System clock rate.
    localparam int CLK_KHZ        = 10000;
    // Lock window as a time, in picoseconds, and as whole clock cycles (floor, at least 1).
    localparam int WIN_PS         = 3700;
    localparam int WIN_CYC_RAW    = (WIN_PS / 1000) * CLK_KHZ / 1000000;
    localparam int WIN_CYC        = (WIN_CYC_RAW < 1) ? 1 : WIN_CYC_RAW;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_REF_DIV   = 8'h04;
    localparam logic [7:0] OFS_FB_DIV    = 8'h08;
    localparam logic [7:0] OFS_OUT_DIV0  = 8'h0c;
    localparam logic [7:0] OFS_OUT_DIV1  = 8'h10;
    localparam logic [7:0] OFS_LOCK_CNT  = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;

    // Field positions.
    localparam int BIT_DOUBLER    = 0;
    localparam int POS_PRESC      = 24;
    localparam int BIT_ST_LOCK    = 0;
    localparam int BIT_ST_CAL     = 1;
    localparam int POS_ST_COUNT   = 16;
    localparam int IRQ_LOCKED     = 0;
    localparam int IRQ_LOST       = 1;
    localparam int IRQ_CAL_DONE   = 2;

    // Field widths.
    localparam int REF_W          = 12;
    localparam int N_W            = 18;
    localparam int OUT_W          = 11;
    localparam int THR_W          = 16;
    localparam int IRQ_W          = 3;

    // Values after reset, and calibration settings.
    localparam logic [REF_W-1:0] RST_REF_DIV  = 12'h001;
    localparam logic [N_W-1:0]   RST_N_DIV    = 18'h00001;
    localparam logic [2:0]       RST_PRESC    = 3'h2;
    localparam logic [OUT_W-1:0] RST_OUT_DIV  = 11'h002;
    localparam logic [THR_W-1:0] RST_LOCK_CNT = 16'h0400;
    localparam logic [N_W-1:0]   CAL_N_DIV    = 18'h00001;
    localparam logic [7:0]       CAL_CYCLES   = 8'h40;

    typedef enum logic [1:0]
    {
        PLLDL_IDLE     = 2'b00,
        PLLDL_WAIT_FB  = 2'b01,
        PLLDL_WAIT_REF = 2'b10
    } plldl_ld_state_t;
endpackage

`default_nettype wire

// File: plldl_properties.sv
/*
 * Port-level checker for the PLL divider chain and lock detector.
 * Assumes it is bound to plldl_top and that reset is asynchronous and active high.
 */
`default_nettype none

module plldl_properties
    import plldl_pkg::*;
(
    // System.
    input  wire logic        clk,
    input  wire logic        reset,
    // Register bus.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Pins and status.
    input  wire logic        reference_input,
    input  wire logic        vco_input,
    input  wire logic        reference_buffered_output,
    input  wire logic        lock_detect,
    input  wire logic        cal_busy,
    input  wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic [7:0] stall_r;
    logic [2:0] up_r;
    logic       vco_d_r;

    // A stalled feedback pin is measured in cycles, far too long to unroll.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stall_r <= 8'h00;
            up_r <= 3'h0;
            vco_d_r <= 1'b0;
        end
        else
        begin
            vco_d_r <= vco_input;
            stall_r <= (vco_input != vco_d_r) ? 8'h00 : stall_r + {7'h00, stall_r != 8'hff};
            up_r <= up_r + {2'h0, up_r != 3'h4};
        end
    end

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_reply: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h24
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_fb_cal: assert property (wb_ack_o && wb_we_i && wb_adr_i == OFS_FB_DIV
        |-> ##[1:2] cal_busy)
        else $error("feedback write did not start calibration");
    a_cal_no_lock: assert property (cal_busy && $past(cal_busy) |-> !lock_detect)
        else $error("lock shown during calibration");
    a_thr_restart: assert property (wb_ack_o && wb_we_i && wb_adr_i == OFS_LOCK_CNT
        |-> ##[1:2] !lock_detect)
        else $error("threshold write kept lock");
    a_stall_unlock: assert property (stall_r == 8'hff |-> !lock_detect)
        else $error("lock kept with feedback stalled");
    a_lock_fed: assert property ($rose(lock_detect) |-> stall_r < 8'h08)
        else $error("lock rose without feedback edges");
    a_ref_buffer: assert property (up_r == 3'h4
        |-> reference_buffered_output == $past(reference_input, 3))
        else $error("buffered reference latency wrong");

    c_locked: cover property ($rose(lock_detect));
    c_lost: cover property ($fell(lock_detect));
    c_cal_done: cover property ($fell(cal_busy));
    c_irq: cover property ($rose(irq));
endmodule

`default_nettype wire

// File: plldl_src_model.sv
/*
 * Source model: reference and VCO pins, scaled down to the system clock.
 * Assumes ref_half gives a reference period that is a multiple of four cycles.
 */
`default_nettype none

module plldl_src_model
(
    // Timing and control.
    input  wire logic       clk,
    input  wire logic       vco_run,
    input  wire logic       slip,
    input  wire logic [7:0] ref_half,
    // Pins.
    output logic            reference_input,
    output logic            vco_input
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [8:0] phase_r = 9'h000;
    logic [2:0] hold_r = 3'h0;
    logic       pend_r = 1'b0;

    // A slip drops one whole VCO period, moving the feedback divider phase by one.
    always_ff @(posedge clk)
    begin
        phase_r <= (phase_r >= {ref_half, 1'b0} - 9'h001) ? 9'h000 : phase_r + 9'h001;
        if (pend_r && phase_r[1:0] == 2'h3)
            hold_r <= 3'h4;
        else if (hold_r != 3'h0)
            hold_r <= hold_r - 3'h1;
        pend_r <= slip | (pend_r & (phase_r[1:0] != 2'h3));
    end

    assign reference_input = phase_r < {1'b0, ref_half};
    // The VCO is cut from the reference phase counter, so both paths share one time base.
    // Its rate never changes, which stands for a VCO kept inside its tuning range.
    assign vco_input = vco_run && hold_r == 3'h0 && phase_r[1:0] < 2'h2;
endmodule

`default_nettype wire

// File: plldl_tb.sv
/*
 * Self-checking bench for the PLL divider chain with lock detect.
 * Assumes plldl_top, its package, the source model and the checker.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import plldl_pkg::*;

    localparam int PC[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 4, 2};
    localparam int PT[10] = '{8, 2, 2, 3, 4, 5, 6, 7, 4, 6};
    localparam int DB[10] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 0};
    localparam int RD[10] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 2};
    localparam int NN[10] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 3};
    localparam logic [7:0] RA[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24};
    localparam logic [31:0] RV[8] = '{32'h0, 32'h1, 32'h02000001, 32'h2, 32'h2, 32'h400,
                                      32'h0, 32'h0};
    localparam logic [31:0] RO[8] = '{32'h1, 32'hfff, 32'h0703ffff, 32'h7ff, 32'h7ff,
                                      32'hffff, 32'h7, 32'h0};

    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        ref_pin;
    logic        vco_pin;
    logic [1:0]  cko;
    logic        lock;
    logic        cal;
    logic        irq;
    logic        vco_run = 1'b1;
    logic        slip = 1'b0;
    logic [7:0]  ref_half = 8'h10;
    int          miscompares = 0;
    int          tests_run = 0;
    logic [31:0] rd;
    bit          got;
    int          n;

    always #50 clk = ~clk;

    plldl_top DUT (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .reference_input(ref_pin), .vco_input(vco_pin), .clock_output(cko),
        .reference_buffered_output(), .lock_detect(lock), .cal_busy(cal), .irq(irq));
    plldl_src_model u_src (.clk(clk), .vco_run(vco_run), .slip(slip), .ref_half(ref_half),
        .reference_input(ref_pin), .vco_input(vco_pin));

    task automatic wrap_up;
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic give_up;
        miscompares++;
        $display("unexpected at %0t: wait ran out", $time);
        wrap_up();
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        if (ack !== 1'b1)
            give_up();
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    // Feedback phase is unknown after calibration, so slip until the edges meet.
    task automatic try_lock(input int lim, output bit ok);
        ok = 1'b0;
        for (int t = 0; t < 9 && !ok; t++)
        begin
            for (int k = 0; k < lim && !ok; k++)
            begin
                @(posedge clk);
                ok = (lock === 1'b1);
            end
            slip <= !ok;
            @(posedge clk);
            slip <= 1'b0;
        end
    endtask

    task automatic period_of(input int ch, output int p);
        int k;
        int t0;
        logic prev;
        k = 0;
        t0 = 0;
        prev = cko[ch];
        for (int t = 0; t < 20000 && k < 3; t++)
        begin
            @(posedge clk);
            if (cko[ch] === 1'b1 && prev === 1'b0)
            begin
                k++;
                p = t - t0;
                t0 = t;
            end
            prev = cko[ch];
        end
        if (k < 3)
            give_up();
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        give_up();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, RA[i], 32'h0, rd);
            check(rd, RV[i]);
            bus(1'b1, RA[i], 32'hffffffff, rd);
            bus(1'b0, RA[i], 32'h0, rd);
            check(rd, RO[i]);
        end
        $display("test registers done");
        for (int i = 0; i < 10; i++)
        begin
            ref_half <= 8'(PT[i] * (DB[i] + 1) * 2 / RD[i]);
            bus(1'b1, OFS_CTRL, 32'(DB[i]), rd);
            bus(1'b1, OFS_REF_DIV, 32'(RD[i]), rd);
            bus(1'b1, OFS_LOCK_CNT, 32'h4, rd);
            bus(1'b1, OFS_FB_DIV, 32'(PC[i] * 32'h01000000 + NN[i]), rd);
            repeat (2) @(posedge clk);
            for (n = 0; n < 4000 && cal !== 1'b0; n++)
                @(posedge clk);
            check(cal, 1'b0);
            try_lock(32 * PT[i], got);
            check(got, 1'b1);
        end
        $display("test divider settings done");
        bus(1'b1, OFS_IRQ_MASK, 32'h0, rd);
        bus(1'b0, OFS_IRQ_STAT, 32'h0, rd);
        check(rd & 32'h5, 32'h5);
        check(irq, 1'b0);
        bus(1'b1, OFS_IRQ_MASK, 32'h1, rd);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        bus(1'b1, OFS_IRQ_STAT, 32'h7, rd);
        bus(1'b0, OFS_IRQ_STAT, 32'h0, rd);
        check(rd, 32'h0);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        check(rd[0], 1'b1);
        n = 0;
        repeat (100)
        begin
            @(posedge clk);
            n += (lock !== 1'b1);
        end
        check(n, 0);
        vco_run <= 1'b0;
        for (n = 0; n < 300 && lock !== 1'b0; n++)
            @(posedge clk);
        check(lock, 1'b0);
        bus(1'b1, OFS_IRQ_MASK, 32'h2, rd);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        vco_run <= 1'b1;
        try_lock(192, got);
        check(got, 1'b1);
        bus(1'b1, OFS_LOCK_CNT, 32'h8, rd);
        for (n = 0; n < 400 && lock !== 1'b1; n++)
            @(posedge clk);
        check(n >= 160 && n <= 240, 1'b1);
        $display("test lock events done");
        bus(1'b1, OFS_OUT_DIV0, 32'h3, rd);
        bus(1'b1, OFS_OUT_DIV1, 32'h415, rd);
        period_of(0, n);
        check(n, 12);
        period_of(1, n);
        check(n, 4180);
        $display("test output dividers done");
        wrap_up();
    end
endmodule

bind plldl_top plldl_properties u_props (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .reference_input(reference_input), .vco_input(vco_input),
    .reference_buffered_output(reference_buffered_output), .lock_detect(lock_detect),
    .cal_busy(cal_busy), .irq(irq));

`default_nettype wire

// File: plldl_top.sv
/*
 * Integer-N PLL divider chain with digital lock detect, behind a classic Wishbone slave.
 * Assumes reference and VCO feedback arrive as pins slower than clk/2; both are
 * synchronised with two flip-flops and their edges counted in the clk domain.
 */
// Register access over Wishbone and the register addresses were left to the implementer.
`default_nettype none

// What this block does
// - Reference edges count once, or twice when doubled, and R of them make one pd pulse.
// - The reference divider takes 1 to 4095, with 0 treated as 1.
// - The prescaler between VCO and feedback divider divides by 2 to 8.
// - The feedback divider takes 1 to 262143 and the total feedback division is P times N.
// - Each output channel divides the VCO by its own even or odd value up to 2047.
// - A phase detector cycle is good only when both divided edges fall inside the window.
// - Lock is declared only after the programmed number of good cycles.
// - An edge outside the window clears the good-cycle count to zero.
// - Writing the feedback divider register runs a calibration using a separate divide value.
// - Prescaler code 0 divides by 8, codes 1 and 2 by 2, codes 3 to 7 by their value.
module plldl_top
(
    // System.
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Wishbone slave.
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // Clock pins.
    input  wire logic                     reference_input,
    input  wire logic                     vco_input,
    output logic      [1:0]               clock_output,
    output logic                          reference_buffered_output,
    // Status.
    output logic                          lock_detect,
    output logic                          cal_busy,
    output logic                          irq
);
    import plldl_pkg::*;

    function automatic logic [3:0] presc_value(input logic [2:0] code);
        if (code == 3'h0)
            presc_value = 4'h8;
        else if (code < 3'h3)
            presc_value = 4'h2;
        else
            presc_value = {1'b0, code};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int i = 0; i < 4; i++)
            merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
    endfunction

    logic [2:0]        ref_sync_r;
    logic [2:0]        vco_sync_r;
    logic              doubler_r;
    logic [2:0]        presc_r;
    logic [REF_W-1:0]  ref_div_r;
    logic [N_W-1:0]    n_div_r;
    logic [OUT_W-1:0]  out_div_r [2];
    logic [THR_W-1:0]  thr_r;
    logic [IRQ_W-1:0]  irq_stat_r;
    logic [IRQ_W-1:0]  irq_mask_r;
    logic [REF_W-1:0]  ref_cnt_r;
    logic [3:0]        p_cnt_r;
    logic [N_W-1:0]    n_cnt_r;
    logic [OUT_W-1:0]  out_cnt_r [2];
    logic [7:0]        cal_cnt_r;
    logic [THR_W-1:0]  good_cnt_r;
    logic [7:0]        win_r;
    logic              ref_pd_r;
    logic              fb_pd_r;
    plldl_ld_state_t   ld_st_r;
    plldl_ld_state_t   ld_st_nxt;
    logic              good_nxt;
    logic              bad_nxt;
    logic              wr_go;
    logic              wr_fb;
    logic              wr_thr;
    logic              ref_ev;
    logic              vco_ev;
    logic              p_ev;
    logic [REF_W-1:0]  ref_lim;
    logic [N_W-1:0]    n_lim;
    logic [IRQ_W-1:0]  irq_ev;
    logic [31:0]       wdat;
    logic [31:0]       rdat;

    // Pin synchronisers; only stages 1 and 2 feed logic.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ref_sync_r <= 3'h0;
            vco_sync_r <= 3'h0;
        end
        else
        begin
            ref_sync_r <= {ref_sync_r[1:0], reference_input};
            vco_sync_r <= {vco_sync_r[1:0], vco_input};
        end
    end

    assign ref_ev = doubler_r ? (ref_sync_r[2] ^ ref_sync_r[1])
                              : (ref_sync_r[1] & ~ref_sync_r[2]);
    assign vco_ev = vco_sync_r[1] & ~vco_sync_r[2];
    assign ref_lim = (ref_div_r == 12'h000) ? 12'h001 : ref_div_r;
    assign n_lim = cal_busy ? CAL_N_DIV
                 : ((n_div_r == 18'h00000) ? 18'h00001 : n_div_r);
    assign p_ev = vco_ev && (p_cnt_r == presc_value(presc_r) - 4'h1);

    // Bus write strobe: a write lands on the edge where the master sees ack.
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wr_fb = wr_go && (wb_adr_i == OFS_FB_DIV);
    assign wr_thr = wr_go && (wb_adr_i == OFS_LOCK_CNT);

    always_comb
    begin
        case (wb_adr_i)
            OFS_CTRL:     rdat = {31'h0, doubler_r};
            OFS_REF_DIV:  rdat = {20'h0, ref_div_r};
            OFS_FB_DIV:   rdat = {5'h0, presc_r, 6'h0, n_div_r};
            OFS_OUT_DIV0: rdat = {21'h0, out_div_r[0]};
            OFS_OUT_DIV1: rdat = {21'h0, out_div_r[1]};
            OFS_LOCK_CNT: rdat = {16'h0, thr_r};
            OFS_STATUS:   rdat = {good_cnt_r, 14'h0, cal_busy, lock_detect};
            OFS_IRQ_STAT: rdat = {29'h0, irq_stat_r};
            OFS_IRQ_MASK: rdat = {29'h0, irq_mask_r};
            default:      rdat = 32'h0;
        endcase
        wdat = merge(rdat, wb_dat_i, wb_sel_i);
    end

    // Wishbone answer: ack one cycle after the request, dropped the cycle after.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rdat;
        end
    end

    // Configuration registers.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            doubler_r    <= 1'b0;
            ref_div_r    <= RST_REF_DIV;
            n_div_r      <= RST_N_DIV;
            presc_r      <= RST_PRESC;
            out_div_r[0] <= RST_OUT_DIV;
            out_div_r[1] <= RST_OUT_DIV;
            thr_r        <= RST_LOCK_CNT;
            irq_mask_r   <= 3'h0;
        end
        else if (wr_go)
        begin
            case (wb_adr_i)
                OFS_CTRL:     doubler_r <= wdat[BIT_DOUBLER];
                OFS_REF_DIV:  ref_div_r <= wdat[REF_W-1:0];
                OFS_FB_DIV:
                begin
                    n_div_r <= wdat[N_W-1:0];
                    presc_r <= wdat[POS_PRESC +: 3];
                end
                OFS_OUT_DIV0: out_div_r[0] <= wdat[OUT_W-1:0];
                OFS_OUT_DIV1: out_div_r[1] <= wdat[OUT_W-1:0];
                OFS_LOCK_CNT: thr_r <= wdat[THR_W-1:0];
                OFS_IRQ_MASK: irq_mask_r <= wdat[IRQ_W-1:0];
                default:      ;
            endcase
        end
    end

    // Reference and feedback dividers, producing one phase detector pulse per period.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ref_cnt_r <= 12'h000;
            p_cnt_r   <= 4'h0;
            n_cnt_r   <= 18'h00000;
            ref_pd_r  <= 1'b0;
            fb_pd_r   <= 1'b0;
        end
        else
        begin
            ref_pd_r <= 1'b0;
            fb_pd_r  <= 1'b0;
            if (ref_ev)
            begin
                if (ref_cnt_r >= ref_lim - 12'h001)
                begin
                    ref_cnt_r <= 12'h000;
                    ref_pd_r  <= 1'b1;
                end
                else
                    ref_cnt_r <= ref_cnt_r + 12'h001;
            end
            if (vco_ev)
                p_cnt_r <= p_ev ? 4'h0 : p_cnt_r + 4'h1;
            // A shrinking divider cannot strand the count above its limit.
            if (p_ev)
            begin
                if (n_cnt_r >= n_lim - 18'h00001)
                begin
                    n_cnt_r <= 18'h00000;
                    fb_pd_r <= 1'b1;
                end
                else
                    n_cnt_r <= n_cnt_r + 18'h00001;
            end
        end
    end

    // Output channel dividers; high for the first half of each period of D VCO edges.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            out_cnt_r[0]              <= 11'h000;
            out_cnt_r[1]              <= 11'h000;
            clock_output              <= 2'h0;
            reference_buffered_output <= 1'b0;
        end
        else
        begin
            reference_buffered_output <= ref_sync_r[1];
            for (int c = 0; c < 2; c++)
            begin
                if (out_div_r[c] <= 11'h001)
                    clock_output[c] <= vco_sync_r[1];
                else if (vco_ev)
                begin
                    if (out_cnt_r[c] >= out_div_r[c] - 11'h001)
                        out_cnt_r[c] <= 11'h000;
                    else
                        out_cnt_r[c] <= out_cnt_r[c] + 11'h001;
                    clock_output[c] <= (out_cnt_r[c] < (out_div_r[c] >> 1));
                end
            end
        end
    end

    // Window check between reference and feedback phase detector pulses.
    always_comb
    begin
        ld_st_nxt = ld_st_r;
        good_nxt  = 1'b0;
        bad_nxt   = 1'b0;
        case (ld_st_r)
            PLLDL_IDLE:
            begin
                if (ref_pd_r && fb_pd_r)
                    good_nxt = 1'b1;
                else if (ref_pd_r)
                    ld_st_nxt = PLLDL_WAIT_FB;
                else if (fb_pd_r)
                    ld_st_nxt = PLLDL_WAIT_REF;
            end
            PLLDL_WAIT_FB:
            begin
                good_nxt  = fb_pd_r;
                bad_nxt   = !fb_pd_r && (ref_pd_r || win_r >= 8'(WIN_CYC));
                ld_st_nxt = ref_pd_r ? PLLDL_WAIT_FB
                          : ((fb_pd_r || bad_nxt) ? PLLDL_IDLE : PLLDL_WAIT_FB);
            end
            PLLDL_WAIT_REF:
            begin
                good_nxt  = ref_pd_r;
                bad_nxt   = !ref_pd_r && (fb_pd_r || win_r >= 8'(WIN_CYC));
                ld_st_nxt = fb_pd_r ? PLLDL_WAIT_REF
                          : ((ref_pd_r || bad_nxt) ? PLLDL_IDLE : PLLDL_WAIT_REF);
            end
            default:
                ld_st_nxt = PLLDL_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ld_st_r <= PLLDL_IDLE;
            win_r   <= 8'h00;
        end
        else
        begin
            ld_st_r <= ld_st_nxt;
            win_r   <= (ld_st_nxt != ld_st_r || good_nxt || bad_nxt) ? 8'h00 : win_r + 8'h01;
        end
    end

    // Good-cycle count and lock flag; a calibration run also counts as loss of lock.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            good_cnt_r  <= 16'h0000;
            lock_detect <= 1'b0;
        end
        else if (wr_thr || bad_nxt || cal_busy)
        begin
            good_cnt_r  <= 16'h0000;
            lock_detect <= 1'b0;
        end
        else if (good_nxt)
        begin
            if (good_cnt_r < thr_r)
                good_cnt_r <= good_cnt_r + 16'h0001;
            lock_detect <= (good_cnt_r + 17'h00001 >= {1'b0, thr_r});
        end
    end

    // Calibration: runs CAL_CYCLES feedback periods on the calibration divider.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cal_busy  <= 1'b0;
            cal_cnt_r <= 8'h00;
        end
        else if (wr_fb)
        begin
            cal_busy  <= 1'b1;
            cal_cnt_r <= 8'h00;
        end
        else if (cal_busy && fb_pd_r)
        begin
            cal_cnt_r <= cal_cnt_r + 8'h01;
            if (cal_cnt_r == CAL_CYCLES - 8'h01)
                cal_busy <= 1'b0;
        end
    end

    assign irq_ev[IRQ_LOCKED]   = good_nxt && !lock_detect && !wr_thr && !cal_busy
                                  && (good_cnt_r + 17'h00001 >= {1'b0, thr_r});
    assign irq_ev[IRQ_LOST]     = lock_detect && (bad_nxt || wr_thr || cal_busy);
    assign irq_ev[IRQ_CAL_DONE] = cal_busy && fb_pd_r && !wr_fb
                                  && (cal_cnt_r == CAL_CYCLES - 8'h01);

    // Sticky status: a new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irq_stat_r <= 3'h0;
            irq        <= 1'b0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~((wr_go && wb_adr_i == OFS_IRQ_STAT)
                          ? wdat[IRQ_W-1:0] : 3'h0)) | irq_ev;
            irq        <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule

`default_nettype wire
